/* verilog/ssb_top.sv */
// Top level: serial status flags, baud register and AXI4-Lite register slave
`timescale 1ns/1ps

// Functional notes
// [R01] Buffer-empty flag: set on empty, cleared by read-then-write
// [R02] Complete flag: set on idle, read-then-write clears
// [R03] Receive-full flag: set on char, read-then-read clears
// [R04] Idle flag sets once per busy-to-idle transition
// [R05] Idle flag suppressed while receiver sleeps
// [R06] Idle flag cleared by status then data read
// [R07] Overrun when new char meets unread char
// [R08] Noise flag on non-unanimous bit sampling
// [R09] Framing flag when stop bit samples zero
// [R10] Status flags drive the interrupt logic
// [R11] Prescaler divides bus clock by 1, 3, 4, 13, 39
// [R12] Divider stage divides by two to the n
// [R13] Reset clears upper five baud bits only
// [R14] Software writes baud register once at start
// [R15] Extended prescale set keeps lower bits zero
// [R16] Baud register at its fixed index, field order
// [R17] Top baud bit clears the rate counters
// [R18] Timing tick is 16x, bit tick divides by 16
// [R19] Sleep keeps wakeup on, blocks receive flags
// [R20] Status read arms only the flags seen set
// [R21] Status bit zero always reads zero
module ssb_top (
   input  wire logic        aclk,          // Bus clock, 25 MHz
   input  wire logic        aresetn,       // Sync reset, active low
   input  wire logic [31:0] awaddr,        // Write address
   input  wire logic        awvalid,       // Write address valid
   output wire logic        awready,       // Write address ready
   input  wire logic [31:0] wdata,         // Write data
   input  wire logic [3:0]  wstrb,         // Write strobes
   input  wire logic        wvalid,        // Write data valid
   output wire logic        wready,        // Write data ready
   output wire logic [1:0]  bresp,         // Write response
   output wire logic        bvalid,        // Write response valid
   input  wire logic        bready,        // Write response ready
   input  wire logic [31:0] araddr,        // Read address
   input  wire logic        arvalid,       // Read address valid
   output wire logic        arready,       // Read address ready
   output wire logic [31:0] rdata,         // Read data
   output wire logic [1:0]  rresp,         // Read response
   output wire logic        rvalid,        // Read data valid
   input  wire logic        rready,        // Read data ready
   input  wire logic        tx_empty_evt,  // Transmit buffer went empty
   input  wire logic        tx_idle_evt,   // Transmitter went idle
   output wire logic [7:0]  tx_data,       // Byte for the transmitter
   output wire logic        tx_load,       // Pulse: tx_data written
   input  wire logic        rx_char_evt,   // Pulse: character received
   input  wire logic [7:0]  rx_char,       // Received character
   input  wire logic        rx_noise,      // Sampling not unanimous
   input  wire logic        rx_stop_bit,   // Sampled stop bit level
   input  wire logic        rx_line_idle,  // Receive line idle level
   input  wire logic        wake_evt,      // Pulse: wakeup detected
   output wire logic        sleep_ctrl,    // Receiver sleep level
   output wire logic [7:0]  status_flags,  // Flags to interrupt logic
   output wire logic        rt_tick,       // 16x timing tick
   output wire logic        bit_tick       // Bit rate tick
);

   // ****************************************
   // Bus slave state
   // ****************************************
   logic        aw_have_reg, aw_have_next;
   logic [31:0] aw_addr_reg, aw_addr_next;
   logic        w_have_reg, w_have_next;
   logic [7:0]  w_byte_reg, w_byte_next;
   logic        w_lane_reg, w_lane_next;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic        do_wr, do_rd;
   logic        wr_baud, wr_data, wr_ctrl;
   logic        rd_status, rd_data;

   assign awready = !aw_have_reg;
   assign wready  = !w_have_reg;
   assign arready = !rvalid_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign rvalid  = rvalid_reg;
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;

   // ****************************************
   // Block state
   // ****************************************
   logic [4:0] baud_hi_reg, baud_hi_next;
   logic [2:0] baud_lo_reg, baud_lo_next;
   logic       sleep_reg, sleep_next;
   logic [7:0] flags_reg, flags_next;
   logic [7:0] armed_reg, armed_next;
   logic       idle_armed_reg, idle_armed_next;
   logic [7:0] rx_buf_reg, rx_buf_next;
   logic [7:0] tx_data_reg, tx_data_next;
   logic       tx_load_reg, tx_load_next;
   logic [7:0] baud_val, flag_set, flag_clr;
   logic       rx_xfer, rx_ovr, idle_set;

   assign baud_val = {baud_hi_reg, baud_lo_reg};

   // ****************************************
   // Bus slave: writes after both halves, one read at a time
   // ****************************************
   always_comb begin
      aw_have_next = aw_have_reg;
      aw_addr_next = aw_addr_reg;
      w_have_next = w_have_reg;
      w_byte_next = w_byte_reg;
      w_lane_next = w_lane_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      wr_baud = 1'b0;
      wr_data = 1'b0;
      wr_ctrl = 1'b0;
      rd_status = 1'b0;
      rd_data = 1'b0;
      if (awvalid && awready) begin
         aw_have_next = 1'b1;
         aw_addr_next = awaddr;
      end
      if (wvalid && wready) begin
         w_have_next = 1'b1;
         w_byte_next = wdata[7:0];
         w_lane_next = wstrb[0];
      end
      if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
      do_wr = aw_have_reg && w_have_reg && !bvalid_reg;
      if (do_wr) begin
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = ssb_pkg::RESP_OKAY;
         // Only the low lane holds register bits
         if (ssb_pkg::hit(aw_addr_reg, ssb_pkg::BAUD_IDX)) begin // see [R16]
            wr_baud = w_lane_reg;
         end else if (ssb_pkg::hit(aw_addr_reg, ssb_pkg::DATA_IDX)) begin
            wr_data = w_lane_reg;
         end else if (ssb_pkg::hit(aw_addr_reg, ssb_pkg::CTRL_IDX)) begin
            wr_ctrl = w_lane_reg;
         end else if (!ssb_pkg::hit(aw_addr_reg, ssb_pkg::STATUS_IDX)) begin
            bresp_next = ssb_pkg::RESP_SLVERR;
         end
      end
      if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
      do_rd = arvalid && arready;
      if (do_rd) begin
         rvalid_next = 1'b1;
         rresp_next = ssb_pkg::RESP_OKAY;
         rdata_next = 32'h0000_0000;
         if (ssb_pkg::hit(araddr, ssb_pkg::BAUD_IDX)) begin
            rdata_next[7:0] = baud_val;
         end else if (ssb_pkg::hit(araddr, ssb_pkg::STATUS_IDX)) begin
            rd_status = 1'b1;
            rdata_next[7:0] = flags_reg;
         end else if (ssb_pkg::hit(araddr, ssb_pkg::DATA_IDX)) begin
            rd_data = 1'b1;
            rdata_next[7:0] = rx_buf_reg;
         end else if (ssb_pkg::hit(araddr, ssb_pkg::CTRL_IDX)) begin
            rdata_next[ssb_pkg::CTRL_SLEEP] = sleep_reg;
         end else begin
            rresp_next = ssb_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 32'h0000_0000;
         w_have_reg <= 1'b0;
         w_byte_reg <= 8'h00;
         w_lane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'h0;
      end else begin
         aw_have_reg <= aw_have_next;
         aw_addr_reg <= aw_addr_next;
         w_have_reg <= w_have_next;
         w_byte_reg <= w_byte_next;
         w_lane_reg <= w_lane_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // ****************************************
   // Flags, clearing sequences, data buffers
   // ****************************************
   always_comb begin
      // Sleep blocks every receiver flag, not just the idle flag
      rx_xfer = rx_char_evt && !sleep_reg && !flags_reg[ssb_pkg::ST_RX_FULL]
                && !flags_reg[ssb_pkg::ST_FRAME]; // see [R19]
      rx_ovr = rx_char_evt && !sleep_reg && !rx_xfer; // see [R07]
      idle_set = rx_line_idle && idle_armed_reg && !sleep_reg; // see [R05]
      flag_set = 8'h00;
      flag_set[ssb_pkg::ST_TX_EMPTY] = tx_empty_evt; // see [R01]
      flag_set[ssb_pkg::ST_TX_DONE] = tx_idle_evt; // see [R02]
      flag_set[ssb_pkg::ST_RX_FULL] = rx_xfer; // see [R03]
      flag_set[ssb_pkg::ST_IDLE] = idle_set; // see [R04]
      flag_set[ssb_pkg::ST_OVR] = rx_ovr; // see [R07]
      flag_set[ssb_pkg::ST_NOISE] = rx_xfer && rx_noise; // see [R08]
      flag_set[ssb_pkg::ST_FRAME] = rx_xfer && !rx_stop_bit; // see [R09]
      flag_clr = 8'h00;
      if (wr_data) begin
         flag_clr = armed_reg & ssb_pkg::TX_CLR_MASK; // see [R01] [R02] [R20]
      end else if (rd_data) begin
         flag_clr = armed_reg & ssb_pkg::RX_CLR_MASK; // see [R06] [R20]
      end
      // New events win over a clear in the same cycle
      flags_next = (flags_reg & ~flag_clr) | flag_set;
      flags_next[ssb_pkg::ST_NONE] = 1'b0; // see [R21]
      armed_next = rd_status ? flags_reg : (armed_reg & ~flag_clr); // see [R20]
      // Line must go busy before the idle flag may set again
      if (!rx_line_idle) begin
         idle_armed_next = 1'b1; // see [R04]
      end else if (idle_armed_reg) begin
         idle_armed_next = 1'b0;
      end else begin
         idle_armed_next = idle_armed_reg;
      end
      rx_buf_next = rx_xfer ? rx_char : rx_buf_reg;
      tx_data_next = wr_data ? w_byte_reg : tx_data_reg;
      tx_load_next = wr_data;
      if (wake_evt) begin
         sleep_next = 1'b0;
      end else if (wr_ctrl) begin
         sleep_next = w_byte_reg[ssb_pkg::CTRL_SLEEP];
      end else begin
         sleep_next = sleep_reg;
      end
      // Undecoded prescale codes run fastest; software keeps them legal
      baud_hi_next = wr_baud ? w_byte_reg[ssb_pkg::BD_CLR:ssb_pkg::BD_CHK] : baud_hi_reg; // see [R15]
      baud_lo_next = wr_baud ? w_byte_reg[ssb_pkg::BD_DV_HI:0] : baud_lo_reg; // see [R14]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_hi_reg <= ssb_pkg::BAUD_HI_RST; // see [R13]
         sleep_reg <= 1'b0;
         flags_reg <= ssb_pkg::FLAGS_RST;
         armed_reg <= 8'h00;
         idle_armed_reg <= 1'b0;
         rx_buf_reg <= 8'h00;
         tx_data_reg <= 8'h00;
         tx_load_reg <= 1'b0;
      end else begin
         baud_hi_reg <= baud_hi_next;
         sleep_reg <= sleep_next;
         flags_reg <= flags_next;
         armed_reg <= armed_next;
         idle_armed_reg <= idle_armed_next;
         rx_buf_reg <= rx_buf_next;
         tx_data_reg <= tx_data_next;
         tx_load_reg <= tx_load_next;
      end
   end

   // Divider select survives reset by design
   always_ff @(posedge aclk) begin
      baud_lo_reg <= baud_lo_next; // see [R13]
   end

   assign status_flags = flags_reg; // see [R10]
   assign sleep_ctrl = sleep_reg; // see [R19]
   assign tx_data = tx_data_reg;
   assign tx_load = tx_load_reg;

   // ****************************************
   // Rate chain
   // ****************************************
   ssb_rate_if rate_bus ();

   assign rate_bus.prescale_sel = baud_hi_reg[ssb_pkg::BD_PS_HI - ssb_pkg::BD_CHK:
                                              ssb_pkg::BD_PS_LO - ssb_pkg::BD_CHK]; // see [R11]
   assign rate_bus.divider_sel = baud_lo_reg; // see [R12]
   assign rate_bus.counter_clear = baud_hi_reg[ssb_pkg::BD_CLR - ssb_pkg::BD_CHK]; // see [R17]
   assign rt_tick = rate_bus.rt_tick;
   assign bit_tick = rate_bus.bit_tick;

   ssb_rate_gen u_rate (
      .aclk    (aclk),
      .aresetn (aresetn),
      .rif     (rate_bus)
   );

   // ****************************************
   // Checks
   // ****************************************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_empty_set: assert property (tx_empty_evt |=> status_flags[ssb_pkg::ST_TX_EMPTY]) // see [R01]
      else $error("empty flag not set");
   a_done_clear: assert property (wr_data && armed_reg[ssb_pkg::ST_TX_DONE] && !tx_idle_evt // see [R02]
      |=> !status_flags[ssb_pkg::ST_TX_DONE]) else $error("complete flag not cleared");
   a_full_set: assert property (rx_char_evt && !sleep_reg && !flags_reg[ssb_pkg::ST_RX_FULL] // see [R03]
      && !flags_reg[ssb_pkg::ST_FRAME] |=> status_flags[ssb_pkg::ST_RX_FULL] && rx_buf_reg == $past(rx_char))
      else $error("received byte not captured");
   a_idle_once: assert property (!idle_armed_reg && rx_line_idle // see [R04]
      |=> !$rose(status_flags[ssb_pkg::ST_IDLE])) else $error("idle flag set twice");
   a_idle_sleep: assert property (sleep_reg |=> !$rose(status_flags[ssb_pkg::ST_IDLE])) // see [R05]
      else $error("idle flag set while asleep");
   a_idle_clear: assert property (rd_data && armed_reg[ssb_pkg::ST_IDLE] && !idle_set // see [R06]
      |=> !status_flags[ssb_pkg::ST_IDLE]) else $error("idle flag not cleared");
   a_ovr_set: assert property (rx_char_evt && !sleep_reg && flags_reg[ssb_pkg::ST_RX_FULL] // see [R07]
      |=> status_flags[ssb_pkg::ST_OVR] && $stable(rx_buf_reg)) else $error("overrun mishandled");
   a_noise_set: assert property (rx_xfer && rx_noise |=> status_flags[ssb_pkg::ST_NOISE]) // see [R08]
      else $error("noise flag not set");
   a_frame_set: assert property (rx_xfer && !rx_stop_bit |=> status_flags[ssb_pkg::ST_FRAME]) // see [R09]
      else $error("framing flag not set");
   a_arm_only: assert property (rd_data && !armed_reg[ssb_pkg::ST_OVR] && flags_reg[ssb_pkg::ST_OVR] // see [R20]
      |=> status_flags[ssb_pkg::ST_OVR]) else $error("unarmed flag cleared");
   a_bit_zero: assert property (!status_flags[ssb_pkg::ST_NONE]) // see [R21]
      else $error("status bit zero set");
   // Reset itself is the trigger, so the default reset gating must not apply here
   a_baud_reset: assert property (disable iff (1'b0) !aresetn |=> baud_hi_reg == ssb_pkg::BAUD_HI_RST) // see [R13]
      else $error("baud upper bits not reset");
   a_wr_answer: assert property (aw_have_reg && w_have_reg && !bvalid_reg |=> bvalid) // see [R16]
      else $error("write not answered");

endmodule // ssb_top

/* verilog/ssb_pkg.sv */
// Package: register map, field layout and rate table for the serial status block
package ssb_pkg;

   // ****************************************
   // Register indices (byte address = 4 * index)
   // ****************************************
   localparam logic [15:0] BAUD_IDX   = 16'h102b;
   localparam logic [15:0] STATUS_IDX = 16'h102e;
   localparam logic [15:0] DATA_IDX   = 16'h102f;
   localparam logic [15:0] CTRL_IDX   = 16'h1030;

   // ****************************************
   // Status flag positions
   // ****************************************
   localparam int ST_TX_EMPTY = 7;
   localparam int ST_TX_DONE  = 6;
   localparam int ST_RX_FULL  = 5;
   localparam int ST_IDLE     = 4;
   localparam int ST_OVR      = 3;
   localparam int ST_NOISE    = 2;
   localparam int ST_FRAME    = 1;
   localparam int ST_NONE = 0;
   localparam logic [7:0] TX_CLR_MASK = 8'hc0;
   localparam logic [7:0] RX_CLR_MASK = 8'h3e;
   localparam logic [7:0] FLAGS_RST   = 8'h00;

   // ****************************************
   // Baud register fields
   // ****************************************
   localparam int BD_CLR   = 7;
   localparam int BD_PS_HI = 6;
   localparam int BD_PS_LO = 4;
   localparam int BD_CHK   = 3;
   localparam int BD_DV_HI = 2;
   localparam logic [4:0] BAUD_HI_RST = 5'h00;
   localparam int CTRL_SLEEP = 0;

   // ****************************************
   // Rate chain
   // ****************************************
   localparam logic [5:0] PS_DIV_1  = 6'h01;
   localparam logic [5:0] PS_DIV_3  = 6'h03;
   localparam logic [5:0] PS_DIV_4  = 6'h04;
   localparam logic [5:0] PS_DIV_13 = 6'h0d;
   localparam logic [5:0] PS_DIV_39 = 6'h27;
   localparam logic [3:0] RT_LAST   = 4'hf;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Undecoded selections fall back to the fastest rate
   function automatic logic [5:0] presc_div(input logic [2:0] sel);
      case (sel)
         3'h1:    presc_div = PS_DIV_3;
         3'h2:    presc_div = PS_DIV_4;
         3'h3:    presc_div = PS_DIV_13;
         3'h4:    presc_div = PS_DIV_39;
         default: presc_div = PS_DIV_1;
      endcase
   endfunction

   function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
      hit = (addr == {14'h0000, idx, 2'h0});
   endfunction

endpackage

/* verilog/ssb_rate_if.sv */
// Interface: rate selections in, timing ticks out
`timescale 1ns/1ps
interface ssb_rate_if;
   logic [2:0] prescale_sel;
   logic [2:0] divider_sel;
   logic       counter_clear;
   logic       rt_tick;
   logic       bit_tick;
   modport gen  (input prescale_sel, divider_sel, counter_clear, output rt_tick, bit_tick);
   modport user (output prescale_sel, divider_sel, counter_clear, input rt_tick, bit_tick);
endinterface

/* verilog/ssb_rate_gen.sv */
// Rate chain: prescaler, binary divider, 16x timing tick and bit tick
`timescale 1ns/1ps
module ssb_rate_gen (
   input wire logic aclk,     // Bus clock
   input wire logic aresetn,  // Sync reset, active low
   ssb_rate_if.gen  rif       // Selections and ticks
);
   logic [5:0] pre_cnt_reg, pre_cnt_next;
   logic [6:0] div_cnt_reg, div_cnt_next;
   logic [3:0] rt_cnt_reg, rt_cnt_next;
   logic       rt_tick_reg, rt_tick_next;
   logic       bit_tick_reg, bit_tick_next;
   logic       pre_tick;
   logic [6:0] div_mask;

   always_comb begin
      // Compare with >= so a smaller divisor never strands the count
      pre_tick = (pre_cnt_reg >= 6'(ssb_pkg::presc_div(rif.prescale_sel) - 6'h01)); // see [R11]
      pre_cnt_next = pre_tick ? 6'h00 : 6'(pre_cnt_reg + 6'h01);
      div_mask = 7'((8'h01 << rif.divider_sel) - 8'h01);
      div_cnt_next = pre_tick ? 7'(div_cnt_reg + 7'h01) : div_cnt_reg;
      rt_tick_next = pre_tick && ((div_cnt_reg & div_mask) == div_mask); // see [R12]
      rt_cnt_next = rt_tick_next ? 4'(rt_cnt_reg + 4'h1) : rt_cnt_reg;
      bit_tick_next = rt_tick_next && (rt_cnt_reg == ssb_pkg::RT_LAST); // see [R18]
      if (rif.counter_clear) begin // see [R17]
         pre_cnt_next = 6'h00;
         div_cnt_next = 7'h00;
         rt_cnt_next = 4'h0;
         rt_tick_next = 1'b0;
         bit_tick_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt_reg <= 6'h00;
         div_cnt_reg <= 7'h00;
         rt_cnt_reg <= 4'h0;
         rt_tick_reg <= 1'b0;
         bit_tick_reg <= 1'b0;
      end else begin
         pre_cnt_reg <= pre_cnt_next;
         div_cnt_reg <= div_cnt_next;
         rt_cnt_reg <= rt_cnt_next;
         rt_tick_reg <= rt_tick_next;
         bit_tick_reg <= bit_tick_next;
      end
   end

   assign rif.rt_tick = rt_tick_reg;
   assign rif.bit_tick = bit_tick_reg;

   a_bit_on_rt: assert property (@(posedge aclk) disable iff (!aresetn) // see [R18]
      rif.bit_tick |-> rif.rt_tick) else $error("bit tick without timing tick");
   a_clear_stops: assert property (@(posedge aclk) disable iff (!aresetn) // see [R17]
      rif.counter_clear |=> !rif.rt_tick) else $error("tick after counter clear");
   a_fast_rate: assert property (@(posedge aclk) disable iff (!aresetn) // see [R11]
      (!rif.counter_clear && rif.prescale_sel == 3'h0 && rif.divider_sel == 3'h0)[*2] |-> rif.rt_tick)
      else $error("fastest rate missed a tick");
endmodule // ssb_rate_gen

/* testbench/ssb_far_model.sv */
// Far-side serial device model: line, character and transmitter events
`timescale 1ns/1ps
module ssb_far_model (
   input  wire logic aclk,          // Bus clock
   output logic      tx_empty_evt,  // Buffer empty pulse
   output logic      tx_idle_evt,   // Transmitter idle pulse
   output logic      rx_char_evt,   // Character done pulse
   output logic[7:0] rx_char,       // Character
   output logic      rx_noise,      // Noisy sampling
   output logic      rx_stop_bit,   // Stop bit level
   output logic      rx_line_idle,  // Line idle level
   output logic      wake_evt       // Wakeup pulse
);
   initial begin
      {tx_empty_evt, tx_idle_evt, rx_char_evt, wake_evt, rx_line_idle} = 5'h00;
      {rx_char, rx_noise, rx_stop_bit} = 10'h000;
   end
   task automatic tx_pulse();
      {tx_empty_evt, tx_idle_evt} <= 2'h3;
      @(posedge aclk);
      {tx_empty_evt, tx_idle_evt} <= 2'h0;
   endtask
   // Fields inverted after the pulse so a stale value never passes
   task automatic rx_frame(input logic [7:0] c, input logic nz, input logic sb);
      rx_line_idle <= 1'b0;
      {rx_char, rx_noise, rx_stop_bit, rx_char_evt} <= {c, nz, sb, 1'b1};
      @(posedge aclk);
      {rx_char, rx_noise, rx_stop_bit, rx_char_evt} <= {~c, ~nz, ~sb, 1'b0};
   endtask
   task automatic line(input logic idle);
      rx_line_idle <= idle;
      @(posedge aclk);
   endtask
   task automatic wake();
      wake_evt <= 1'b1;
      @(posedge aclk);
      wake_evt <= 1'b0;
   endtask
endmodule // ssb_far_model

/* testbench/sci_status_and_baud_generator_tb.sv */
// Self-checking bench for the serial status and baud block
`timescale 1ns/1ps
module sci_status_and_baud_generator_tb;
   localparam logic [15:0] BD = ssb_pkg::BAUD_IDX;
   localparam logic [15:0] ST = ssb_pkg::STATUS_IDX;
   localparam logic [15:0] DT = ssb_pkg::DATA_IDX;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd;
   logic [3:0]  wstrb = 0;
   logic        awready, wready, bvalid, arready, rvalid, tx_load, sleep_ctrl, rt_tick, bit_tick;
   logic [1:0]  bresp, rresp, rs;
   logic [7:0]  tx_data, status_flags, rx_char;
   logic        tx_empty_evt, tx_idle_evt, rx_char_evt, rx_noise, rx_stop_bit, rx_line_idle, wake_evt;
   int          errors = 0, total_checks = 0, n;
   logic [7:0]  bd [6] = '{8'h00, 8'h12, 8'h21, 8'h40, 8'h13, 8'h07};
   int          per [6] = '{1, 12, 8, 39, 24, 128};

   always #20 aclk = ~aclk;

   ssb_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .tx_empty_evt,
      .tx_idle_evt, .tx_data, .tx_load, .rx_char_evt, .rx_char, .rx_noise, .rx_stop_bit, .rx_line_idle,
      .wake_evt, .sleep_ctrl, .status_flags, .rt_tick, .bit_tick);
   ssb_far_model far (.aclk, .tx_empty_evt, .tx_idle_evt, .rx_char_evt, .rx_char, .rx_noise, .rx_stop_bit,
      .rx_line_idle, .wake_evt);

   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic finish_test();
      if (errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rst();
      aresetn <= 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      {awaddr, wdata, wstrb} <= {14'h0, idx, 2'h0, 24'h0, d, 4'h1};
      {awvalid, wvalid, bready} <= 3'h7;
      // Ready lines stay high so a following call never re-raises them in the same step
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk("bresp", bresp, 0);
   endtask
   task automatic rdr(input logic [15:0] idx);
      araddr <= {14'h0, idx, 2'h0};
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      {rd, rs} = {rdata, rresp};
   endtask
   task automatic rchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
      rdr(idx);
      chk(what, rd, exp);
   endtask
   // Two periods: the first one after a change may carry the old count
   task automatic period(input logic bt);
      repeat (2) begin
         n = 0;
         do @(posedge aclk); while ((bt ? bit_tick : rt_tick) !== 1'b1);
         do begin
            @(posedge aclk);
            n++;
         end while ((bt ? bit_tick : rt_tick) !== 1'b1);
      end
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      rst();
      @(posedge aclk);
      rdr(BD);
      chk("baud high", rd[7:3], 32'h0);
      rchk("status reset", ST, 32'h0);
      // Unreset divider bits leave the tick counts unknown until a counter clear
      wr(BD, 8'h80);
      for (int i = 0; i < 6; i++) begin
         wr(BD, bd[i]);
         period(1'b0);
         chk("rt period", n, per[i]);
      end
      period(1'b1);
      chk("bit period", n, 32'h800);
      wr(BD, 8'h85);
      n = 0;
      repeat (100) begin
         @(posedge aclk);
         if (rt_tick !== 1'b0) n++;
      end
      chk("held ticks", n, 32'h0);
      wr(BD, 8'h4b);
      rchk("baud rw", BD, 32'h4b);
      wr(BD, 8'h15);
      rst();
      rchk("baud kept", BD, 32'h05);
      far.rx_frame(8'h5a, 1'b1, 1'b1);
      rchk("noise", ST, 32'h24);
      far.rx_frame(8'ha5, 1'b0, 1'b1);
      rchk("rx data", DT, 32'h5a);
      rchk("overrun", ST, 32'h08);
      rchk("ovr data", DT, 32'h5a);
      rchk("rx clear", ST, 32'h0);
      far.rx_frame(8'hc3, 1'b0, 1'b0);
      rchk("framing", ST, 32'h22);
      chk("flag port", status_flags, 8'h22);
      rchk("fe data", DT, 32'hc3);
      rchk("fe clear", ST, 32'h0);
      far.tx_pulse();
      wr(DT, 8'h3c);
      chk("tx data", tx_data, 8'h3c);
      chk("tx load", tx_load, 1'b1);
      rchk("tx unarmed", ST, 32'hc0);
      wr(DT, 8'h3c);
      rchk("tx clear", ST, 32'h0);
      far.line(1'b1);
      far.line(1'b1);
      rchk("idle", ST, 32'h10);
      rdr(DT);
      rchk("idle once", ST, 32'h0);
      wr(ssb_pkg::CTRL_IDX, 8'h01);
      chk("sleep", sleep_ctrl, 1'b1);
      far.line(1'b0);
      far.line(1'b1);
      far.rx_frame(8'h77, 1'b0, 1'b1);
      rchk("asleep", ST, 32'h0);
      far.wake();
      @(posedge aclk);
      chk("awake", sleep_ctrl, 1'b0);
      rdr(16'h1000);
      chk("unmapped", {rs, rd[29:0]}, 32'h80000000);
      finish_test();
   end

   initial begin
      repeat (30000) @(posedge aclk);
      errors++;
      finish_test();
   end
endmodule // sci_status_and_baud_generator_tb
